// [src/prs_power_seq.sv]
// Power-up, brownout and reset sequencer with APB register file
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module prs_power_seq #(
    parameter int SETTLE_CYC = prs_pkg::SETTLE_CYC,
    parameter int INIT_CYC   = prs_pkg::INIT_CYC
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [prs_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          vdd_good,
    input  wire logic                          analog_regulator_out_good,
    input  wire logic                          digital_regulator_out_good,
    input  wire logic                          mode_select_pin_lo,
    input  wire logic                          mode_select_pin_hi,
    input  wire logic                          reset_pin_n,
    output logic                               analog_regulator_en,
    output logic                               digital_regulator_en,
    output logic                               xtal_osc_en,
    output logic                               dsp_logic_reset,
    output logic                               dsp_regs_clear,
    output logic                               serial_port_enable,
    output logic      [prs_pkg::PKCFG_W-1:0]   peak_detect_config_reg,
    output logic                               interrupt_out_b_n,
    output logic                               irq
);
    import prs_pkg::*;

    typedef struct packed {
        logic [2:0]         sup_s1;
        logic [2:0]         sup_s2;
        prs_state_t         st;
        logic [TMR_W-1:0]   tmr;
        logic [STAT_W-1:0]  status;
        logic [STAT_W-1:0]  mask;
        logic [RUN_W-1:0]   run;
        logic [PKCFG_W-1:0] pkcfg;
        logic               low_pwr_seen;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               reg_en;
        logic               osc_en;
        logic               logic_rst;
        logic               clr_pulse;
        logic               serial_en;
        logic               irq_b_n;
        logic               irq;
    } prs_seq_state_t;

    prs_seq_state_t r;
    prs_seq_state_t n;

    prs_qual_if #(.N(3)) qif ();

    prs_pin_qual #(
        .N        (3),
        .QUAL_CYC (QUAL_CYC),
        .INIT     (PIN_INIT)
    ) u_pin_qual (
        .pclk     (pclk),
        .presetn  (presetn),
        .qif      (qif)
    );

    assign qif.raw = {reset_pin_n, mode_select_pin_hi, mode_select_pin_lo};

    // ------------------------------------------------------------------
    // Qualified conditions
    // ------------------------------------------------------------------
    prs_mode_t   mode;
    logic        rst_pin_q_n;
    logic        run_ok;
    logic        all_good;
    logic        serial_ok;
    logic        mapped;
    logic        acc;
    logic        wr;
    logic        rd_status;
    logic [31:0] rd_mux;

    always_comb begin
        mode        = prs_mode_t'(qif.qual[1:0]);
        rst_pin_q_n = qif.qual[2];
        // Low power modes and a held reset pin both drop the rails
        run_ok      = qif.valid && rst_pin_q_n
                      && !mode[1];
        all_good    = &r.sup_s2;
        serial_ok   = (r.st == st_ready) && run_ok;
        acc         = psel && penable && r.pready;
        case (paddr)
            OFS_STATUS:    begin mapped = 1'b1; rd_mux = 32'(r.status); end
            OFS_MASK:      begin mapped = 1'b1; rd_mux = 32'(r.mask);   end
            OFS_CFG_B:     begin mapped = 1'b1; rd_mux = 32'h0000_0000; end
            OFS_RUN:       begin mapped = 1'b1; rd_mux = 32'(r.run);    end
            OFS_PEAK_CFG:  begin mapped = 1'b1; rd_mux = 32'(r.pkcfg);  end
            OFS_SEQ_STATE: begin mapped = 1'b1; rd_mux = 32'(r.st);     end
            default:       begin mapped = 1'b0; rd_mux = 32'h0000_0000; end
        endcase
        wr        = acc && pwrite && serial_ok && mapped;
        rd_status = acc && !pwrite && serial_ok && (paddr == OFS_STATUS);
    end

    // ------------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------------
    logic [STAT_W-1:0] st_set;

    always_comb begin
        n        = r;
        st_set   = '0;
        n.sup_s1 = {vdd_good, analog_regulator_out_good,
                    digital_regulator_out_good};
        n.sup_s2 = r.sup_s1;

        // Counting on pclk keeps timing alive while the crystal is off
        case (r.st)
            st_off: begin
                n.st = st_reg_on;
            end
            st_reg_on: begin
                if (all_good) begin
                    n.st  = st_settle;
                    n.tmr = '0;
                end
            end
            st_settle: begin
                if (!all_good) begin
                    n.st = st_reg_on;
                end else if (r.tmr == TMR_W'(SETTLE_CYC - 1)) begin
                    n.st  = st_osc_wait;
                    n.tmr = '0;
                end else begin
                    n.tmr = r.tmr + 1'b1;
                end
            end
            st_osc_wait: begin
                if (!all_good) begin
                    n.st = st_reg_on;
                end else if (r.tmr == TMR_W'(INIT_CYC - 1)) begin
                    n.st                = st_ready;
                    st_set[ST_INIT_BIT] = 1'b1;
                end else begin
                    n.tmr = r.tmr + 1'b1;
                end
            end
            st_ready: begin
                if (!all_good) begin
                    n.st                 = st_reg_on;
                    st_set[ST_BROWN_BIT] = 1'b1;
                end else if (wr && (paddr == OFS_CFG_B)
                             && pwdata[CFGB_SOFT_RESET_BIT_BIT]) begin
                    n.st  = st_sw_rst;
                    n.tmr = '0;
                end
            end
            st_sw_rst: begin
                if (!all_good) begin
                    n.st = st_reg_on;
                end else if (r.tmr == TMR_W'(SOFT_RESET_BIT_CYC - 1)) begin
                    n.st = st_ready;
                end else begin
                    n.tmr = r.tmr + 1'b1;
                end
            end
            default: begin
                n.st = st_off;
            end
        endcase

        // Pin conditions override every step of the sequence
        if (!run_ok) begin
            if (r.st != st_off) begin
                st_set[ST_SHUT_BIT] = 1'b1;
            end
            n.st = st_off;
        end

        n.reg_en    = (n.st != st_off);
        n.osc_en    = (n.st == st_osc_wait) || (n.st == st_ready)
                      || (n.st == st_sw_rst);
        // Config ranges reload while held; waveform RAM sees no reset
        n.logic_rst = (n.st != st_ready);
        n.serial_en = (n.st == st_ready);

        // Software view resets with the logic, except status and peak config
        if (r.logic_rst) begin
            n.run  = RUN_RST;
            n.mask = MASK_RST;
        end else if (wr) begin
            case (paddr)
                OFS_MASK:     n.mask  = pwdata[STAT_W-1:0];
                OFS_RUN:      n.run   = pwdata[RUN_W-1:0];
                OFS_PEAK_CFG: n.pkcfg = pwdata[PKCFG_W-1:0];
                default:      n.run   = r.run;
            endcase
        end
        n.clr_pulse = (r.run == RUN_RST) && (n.run == RUN_START);

        n.low_pwr_seen = qif.valid && mode[1];
        if (r.low_pwr_seen && qif.valid && !mode[1]) begin
            n.pkcfg = PKCFG_RST;
        end

        // Clear only bits the read returned; a new event always wins
        n.status = (rd_status ? (r.status & ~r.prdata[STAT_W-1:0])
                              : r.status) | st_set;
        n.irq     = |(n.status & n.mask);
        n.irq_b_n = !n.status[ST_INIT_BIT];

        // One wait state; refused access answers with an error
        if (psel && penable && !r.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !serial_ok || !mapped;
            n.prdata  = serial_ok ? rd_mux : 32'h0000_0000;
        end else begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r           <= '0;
            r.st        <= st_off;
            r.status    <= STATUS_RST;
            r.mask      <= MASK_RST;
            r.run       <= RUN_RST;
            r.pkcfg     <= PKCFG_RST;
            r.logic_rst <= 1'b1;
            r.irq_b_n   <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata                 = r.prdata;
    assign pready                 = r.pready;
    assign pslverr                = r.pslverr;
    assign analog_regulator_en    = r.reg_en;
    assign digital_regulator_en   = r.reg_en;
    assign xtal_osc_en            = r.osc_en;
    assign dsp_logic_reset        = r.logic_rst;
    assign dsp_regs_clear         = r.clr_pulse;
    assign serial_port_enable     = r.serial_en;
    assign peak_detect_config_reg = r.pkcfg;
    assign interrupt_out_b_n      = r.irq_b_n;
    assign irq                    = r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run_start;
        r.run == RUN_RST ##1 r.run == RUN_START;
    endsequence

    sequence s_soft_reset_bit_leave;
        r.st == st_sw_rst ##1 r.st == st_ready;
    endsequence

    property p_reg_off;
        !run_ok |=> !r.reg_en && !r.osc_en;
    endproperty
    a_reg_off: assert property (p_reg_off)
        else $error("regulators stayed on without run conditions");

    property p_reg_on;
        (r.st == st_off) && run_ok |=> r.reg_en && !r.osc_en;
    endproperty
    a_reg_on: assert property (p_reg_on)
        else $error("regulators not enabled on run conditions");

    property p_osc_after_settle;
        $rose(r.osc_en) |-> $past(r.st) == st_settle
                            && $past(r.tmr) == TMR_W'(SETTLE_CYC - 1);
    endproperty
    a_osc_after_settle: assert property (p_osc_after_settle)
        else $error("oscillator started before settling time");

    property p_init_flag;
        $rose(r.status[ST_INIT_BIT]) |-> $past(r.st) == st_osc_wait
                     && $past(r.tmr) == TMR_W'(INIT_CYC - 1)
                     && $fell(r.irq_b_n);
    endproperty
    a_init_flag: assert property (p_init_flag)
        else $error("init flag or pin out of step with delay");

    property p_run_clear;
        s_run_start |-> r.clr_pulse ##1 !r.clr_pulse;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("result range clear missing on run start");

    property p_brownout;
        (r.st != st_off) && !all_good |=> r.logic_rst && !r.osc_en
                                          && !r.serial_en;
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("logic not held in reset on brownout");

    property p_no_restart_bad;
        (r.st == st_reg_on) && !all_good |=> (r.st == st_reg_on)
                                             || (r.st == st_off);
    endproperty
    a_no_restart_bad: assert property (p_no_restart_bad)
        else $error("settle timer started with a bad supply");

    property p_soft_reset_bit_len;
        s_soft_reset_bit_leave |-> $past(r.tmr) == TMR_W'(SOFT_RESET_BIT_CYC - 1)
                          && !$past(r.serial_en, 1);
    endproperty
    a_soft_reset_bit_len: assert property (p_soft_reset_bit_len)
        else $error("soft reset length wrong");

    property p_no_serial;
        psel && penable && !r.pready && !serial_ok
            |=> r.pready && r.pslverr && (r.prdata == 32'h0000_0000);
    endproperty
    a_no_serial: assert property (p_no_serial)
        else $error("serial access answered while unavailable");

endmodule // prs_power_seq

// [src/prs_pkg.sv]
// Constants and types shared by the power-up reset sequencer
package prs_pkg;

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 50;
    localparam int SETTLE_TIME_MS   = 20;
    localparam int INIT_DELAY_MS    = 26;
    localparam int QUAL_TIME_US     = 1;
    localparam int SOFT_RESET_BIT_TIME_US    = 60;
    localparam int RUN_CLR_LIMIT_US = 500;
    localparam int SETTLE_CYC       = SETTLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int INIT_CYC         = INIT_DELAY_MS * 1000 * CLK_MHZ;
    localparam int QUAL_CYC         = QUAL_TIME_US * CLK_MHZ;
    localparam int SOFT_RESET_BIT_CYC        = SOFT_RESET_BIT_TIME_US * CLK_MHZ;
    localparam int RUN_CLR_CYC      = RUN_CLR_LIMIT_US * CLK_MHZ;
    localparam int TMR_W            = 21;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] OFS_STATUS      = 8'h00;
    localparam logic [7:0] OFS_MASK        = 8'h04;
    localparam logic [7:0] OFS_CFG_B       = 8'h08;
    localparam logic [7:0] OFS_RUN         = 8'h0C;
    localparam logic [7:0] OFS_PEAK_CFG    = 8'h10;
    localparam logic [7:0] OFS_SEQ_STATE   = 8'h14;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int          STAT_W         = 3;
    localparam int          ST_INIT_BIT    = 0;
    localparam int          ST_BROWN_BIT   = 1;
    localparam int          ST_SHUT_BIT    = 2;
    localparam logic [2:0]  STATUS_RST     = 3'h0;
    localparam logic [2:0]  MASK_RST       = 3'h1;
    localparam int          CFGB_SOFT_RESET_BIT_BIT = 0;
    localparam int          RUN_W          = 16;
    localparam logic [15:0] RUN_RST        = 16'h0000;
    localparam logic [15:0] RUN_START      = 16'h0001;
    localparam int          PKCFG_W        = 8;
    localparam logic [7:0]  PKCFG_RST      = 8'h00;
    localparam logic [2:0]  PIN_INIT       = 3'h4;

    typedef enum logic [1:0] {
        normal_power_mode   = 2'b00,
        tamper_measure_mode = 2'b01,
        peak_detect_mode    = 2'b10,
        idle_mode           = 2'b11
    } prs_mode_t;

    typedef enum logic [2:0] {
        st_off      = 3'b000,
        st_reg_on   = 3'b001,
        st_settle   = 3'b010,
        st_osc_wait = 3'b011,
        st_ready    = 3'b100,
        st_sw_rst   = 3'b101
    } prs_state_t;

endpackage

// [src/prs_qual_if.sv]
// Raw and qualified pin levels between sequencer and pin qualifier
`timescale 1ns/1ps
interface prs_qual_if #(
    parameter int N = 3
);
    logic [N-1:0] raw;
    logic [N-1:0] qual;
    logic         valid;

    modport filt (input raw, output qual, output valid);
    modport user (output raw, input qual, input valid);
endinterface

// [src/prs_pin_qual.sv]
// Two-flop synchroniser and hold-time filter for the control pins
`timescale 1ns/1ps
module prs_pin_qual #(
    parameter int             N        = 3,
    parameter int             QUAL_CYC = prs_pkg::QUAL_CYC,
    parameter logic [N-1:0]   INIT     = prs_pkg::PIN_INIT
) (
    input wire logic pclk,
    input wire logic presetn,
    prs_qual_if.filt qif
);
    import prs_pkg::*;

    localparam int CW = $clog2(QUAL_CYC + 1);

    typedef struct packed {
        logic [N-1:0]  sync1;
        logic [N-1:0]  sync2;
        logic [N-1:0]  last;
        logic [N-1:0]  qual;
        logic          valid;
        logic [CW-1:0] cnt;
    } prs_pq_state_t;

    prs_pq_state_t r;
    prs_pq_state_t n;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    always_comb begin
        n       = r;
        n.sync1 = qif.raw;
        n.sync2 = r.sync1;
        n.last  = r.sync2;
        // Any wiggle restarts the hold window, so short glitches vanish
        if (r.sync2 != r.last) begin
            n.cnt = '0;
        end else if (r.valid && (r.sync2 == r.qual)) begin
            n.cnt = '0;
        end else if (r.cnt == CW'(QUAL_CYC - 1)) begin
            n.qual  = r.sync2;
            n.valid = 1'b1;
            n.cnt   = '0;
        end else begin
            n.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{sync1: INIT, sync2: INIT, last: INIT, qual: INIT,
                   valid: 1'b0, cnt: '0};
        end else begin
            r <= n;
        end
    end

    assign qif.qual  = r.qual;
    assign qif.valid = r.valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_qual_stable;
        @(posedge pclk) disable iff (!presetn)
        $changed(r.qual) |-> $past(r.cnt) == CW'(QUAL_CYC - 1)
                             && $past(r.sync2) == r.qual;
    endproperty
    a_qual_stable: assert property (p_qual_stable)
        else $error("pin level taken before hold window ended");

endmodule // prs_pin_qual

// [tb/prs_host_model.sv]
// Host pin driver and regulator stand-in for the power sequencer
`timescale 1ns/1ps
module prs_host_model (
    input  wire logic       pclk,
    input  wire logic [1:0] mode_req,
    input  wire logic       rst_req_n,
    input  wire logic       reg_en,
    output logic            mode_select_pin_lo,
    output logic            mode_select_pin_hi,
    output logic            reset_pin_n,
    output logic            reg_good
);
    logic [3:0] ramp;
    // Host GPIOs move only on clock edges
    always @(posedge pclk) begin
        {mode_select_pin_hi, mode_select_pin_lo} <= mode_req;
        reset_pin_n <= rst_req_n;
    end
    // Output ramps up slowly, drops at once when disabled
    always @(posedge pclk) begin
        if (!reg_en) ramp <= 4'h0;
        else if (ramp != 4'hF) ramp <= ramp + 4'h1;
    end
    assign reg_good = (ramp == 4'hF);
endmodule // prs_host_model

// [tb/tb.sv]
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/1ps
module tb;
    import prs_pkg::*;
    localparam int SC = 200;
    localparam int IC = 300;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vdd = 1'b1, rst_req_n = 1'b0, good;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] mode_req = 2'b00;
    logic pready, pslverr, er, a_en, d_en, osc, lrst, clr, spe, ib_n, irq;
    logic pm_lo, pm_hi, rpin_n;
    logic [7:0] pk;
    int errors = 0, samples_checked = 0, n, clr_cnt = 0;
    always #10 pclk = ~pclk;
    always @(negedge pclk) if (clr === 1'b1) clr_cnt++;
    prs_power_seq #(.SETTLE_CYC(SC), .INIT_CYC(IC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vdd_good(vdd),
        .analog_regulator_out_good(good), .digital_regulator_out_good(good),
        .mode_select_pin_lo(pm_lo), .mode_select_pin_hi(pm_hi),
        .reset_pin_n(rpin_n), .analog_regulator_en(a_en),
        .digital_regulator_en(d_en), .xtal_osc_en(osc),
        .dsp_logic_reset(lrst), .dsp_regs_clear(clr),
        .serial_port_enable(spe), .peak_detect_config_reg(pk),
        .interrupt_out_b_n(ib_n), .irq(irq));
    prs_host_model host (
        .pclk(pclk), .mode_req(mode_req), .rst_req_n(rst_req_n),
        .reg_en(a_en), .mode_select_pin_lo(pm_lo),
        .mode_select_pin_hi(pm_hi), .reset_pin_n(rpin_n), .reg_good(good));
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return a_en;
            1: return osc;
            2: return ib_n;
            5: return good;
            default: return lrst;
        endcase
    endfunction
    // Cycles counted at falling edges, away from the design's updates
    task wt(input int s, input logic v, input int lim);
        n = 0;
        while (sig(s) !== v) begin
            @(negedge pclk);
            n++;
            if (n > lim) begin
                chk(n, 0);
                complete_run;
            end
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(negedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk(0, 1);
            complete_run;
        end
        rd = prdata;
        er = pslverr;
        // Hold the request through the edge that completes it
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task power_up(input int lim);
        wt(0, 1'b1, 100);
        chk(d_en, 1'b1);
        wt(5, 1'b1, 40);
        wt(1, 1'b1, lim);
        chk(n >= SC && n <= SC + 6, 1'b1);
        wt(2, 1'b0, IC + 10);
        chk(n >= IC && n <= IC + 3, 1'b1);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({lrst, ib_n, a_en}, 3'b110);
        repeat (150) @(negedge pclk);
        chk(a_en, 1'b0);
        rst_req_n <= 1'b1;
        power_up(SC + 10);
        chk({spe, irq}, 2'b11);
        apb(1'b0, OFS_STATUS, 0); chk(rd, 1);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd, 0);
        chk(ib_n, 1'b1);
        apb(1'b0, OFS_MASK, 0); chk(rd, 1);
        apb(1'b0, 8'h20, 0); chk(er, 1'b1);
        apb(1'b1, OFS_RUN, RUN_START);
        apb(1'b1, OFS_RUN, RUN_START);
        chk(clr_cnt, 1);
        apb(1'b1, OFS_PEAK_CFG, 32'h5A);
        rst_req_n <= 1'b0;
        repeat (20) @(posedge pclk);
        rst_req_n <= 1'b1;
        repeat (60) @(negedge pclk);
        chk(a_en, 1'b1);
        // Low power entry by mode pins, not the reset pin
        mode_req <= 2'b11;
        wt(0, 1'b0, 80);
        apb(1'b0, OFS_RUN, 0); chk({er, spe, pk}, 10'h25A);
        repeat (600) @(negedge pclk);
        chk({osc, ib_n}, 2'b01);
        mode_req <= 2'b01;
        power_up(SC + 10);
        chk(pk, 8'h00);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd, 32'h5);
        vdd <= 1'b0;
        wt(6, 1'b1, 10); chk(osc, 1'b0);
        @(posedge pclk);
        vdd <= 1'b1;
        wt(1, 1'b1, SC + 10); chk(n >= SC && n <= SC + 6, 1'b1);
        wt(2, 1'b0, IC + 10);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd, 32'h3);
        rst_req_n <= 1'b0;
        wt(0, 1'b0, 80);
        rst_req_n <= 1'b1;
        power_up(SC + 40);
        apb(1'b1, OFS_RUN, RUN_START);
        apb(1'b1, OFS_CFG_B, 32'h1);
        chk(clr_cnt, 2);
        wt(6, 1'b1, 10);
        wt(6, 1'b0, SOFT_RESET_BIT_CYC + 20);
        chk(n >= SOFT_RESET_BIT_CYC - 10 && n <= SOFT_RESET_BIT_CYC + 10, 1'b1);
        apb(1'b0, OFS_RUN, 0); chk(rd, RUN_RST);
        complete_run;
    end
endmodule // tb
